//--- src/fcp_pkg.sv
// Package for the flash command and protection controller.
// Assumes a 100 MHz clock and an AXI4-Lite register master.
package fcp_pkg;

  // ----------------------------------------
  // Register indices (byte address = 4 x index)
  // ----------------------------------------
  localparam logic [7:0] IDX_PARAM_INDEX = 8'h02;
  localparam logic [7:0] IDX_ECC_INDEX   = 8'h03;
  localparam logic [7:0] IDX_CONFIG      = 8'h04;
  localparam logic [7:0] IDX_FAULT_CFG   = 8'h05;
  localparam logic [7:0] IDX_STATUS      = 8'h06;
  localparam logic [7:0] IDX_FAULT_STAT  = 8'h07;
  localparam logic [7:0] IDX_PPROT       = 8'h08;
  localparam logic [7:0] IDX_DPROT       = 8'h09;
  localparam logic [7:0] IDX_PARAM_HI    = 8'h0a;
  localparam logic [7:0] IDX_PARAM_LO    = 8'h0b;
  localparam logic [7:0] IDX_RSV_A       = 8'h0c;
  localparam logic [7:0] IDX_RSV_B       = 8'h0d;
  localparam logic [7:0] IDX_ECC_HI      = 8'h0e;
  localparam logic [7:0] IDX_ECC_LO      = 8'h0f;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int BIT_CC_IRQ_EN   = 7;
  localparam int BIT_CC_FLAG     = 7;
  localparam int BIT_ACC_ERR     = 5;
  localparam int BIT_PROT_VIOL   = 4;
  localparam int BIT_BUSY        = 3;
  localparam int BIT_VERIFY_ERR  = 1;
  localparam int BIT_VERIFY_UNC  = 0;
  localparam int BIT_DF_IRQ_EN   = 1;
  localparam int BIT_SF_IRQ_EN   = 0;
  localparam int BIT_DF_FLAG     = 1;
  localparam int BIT_SF_FLAG     = 0;
  localparam int BIT_DP_OPEN     = 7;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] RST_DPROT  = 8'h00;
  localparam logic [7:0] RST_STATUS = 8'h80;
  localparam logic [4:0] DPS_FULL   = 5'h1f;

  // ----------------------------------------
  // Commands and memory geometry
  // ----------------------------------------
  localparam logic [7:0]  CMD_ERASE_BLOCK  = 8'h09;
  localparam logic [7:0]  CMD_ERASE_PSECT  = 8'h0a;
  localparam logic [7:0]  CMD_ERASE_DSECT  = 8'h12;
  localparam logic [6:0]  BLK_PROGRAM      = 7'h7f;
  localparam logic [6:0]  BLK_DATA         = 7'h10;
  localparam logic [22:0] DATA_BASE        = 23'h10_0000;
  localparam int          DSECT_BYTES_LOG2 = 8;
  localparam int          PSECT_BYTES_LOG2 = 10;
  localparam int          PHRASE_LOG2      = 3;
  localparam logic [2:0]  SLOT_LAUNCH      = 3'h1;
  localparam int          NUM_SLOTS        = 8;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ       = 100;
  localparam int ERASE_US      = 20;
  localparam int ERASE_CYCLES  = ERASE_US * CLK_MHZ;
  localparam int VERIFY_US     = 2;
  localparam int VERIFY_CYCLES = VERIFY_US * CLK_MHZ;

  typedef enum logic [3:0] {
    FCP_IDLE   = 4'b0001,
    FCP_CHECK  = 4'b0010,
    FCP_ERASE  = 4'b0100,
    FCP_VERIFY = 4'b1000
  } fcp_state_e;

  // Read port of the flash array
  typedef struct packed {
    logic        req;
    logic        block_data;
    logic [15:0] addr;
    logic        word;
  } fcp_rd_req_s;

  typedef struct packed {
    logic        valid;
    logic [15:0] data;
    logic        blocked;
  } fcp_rd_rsp_s;

endpackage

//--- src/fcp_ecc.sv
// SEC-DED decoder for one 64-bit phrase with eight check bits.
// Assumes check bits are stored next to the phrase; purely combinational.
`timescale 1ns/1ps
`default_nettype none
module fcp_ecc (
  input  wire logic [63:0] phrase,
  input  wire logic [7:0]  check,
  output logic      [63:0] fixed,
  output logic             single_err,
  output logic             double_err
);
  import fcp_pkg::*;

  logic [6:0]  syn;
  logic        parity;
  logic [71:0] cw;
  logic [6:0]  pos [64];

  // ----------------------------------------
  // Data bit to codeword position (skip powers of two)
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < 64; g++) begin : g_pos
      localparam int P = g + 3 + (g >= 1 ? 1 : 0) + (g >= 4 ? 1 : 0)
                         + (g >= 11 ? 1 : 0) + (g >= 26 ? 1 : 0) + (g >= 57 ? 1 : 0);
      assign pos[g] = 7'(P);
    end
  endgenerate

  always_comb begin
    syn    = check[6:0];
    parity = ^{phrase, check};
    for (int i = 0; i < 64; i++) begin
      if (phrase[i]) begin
        syn = syn ^ pos[i];
      end
    end
    cw = '0;
    for (int i = 0; i < 64; i++) begin
      cw[pos[i]] = phrase[i];
    end
    if (syn != 7'h00 && parity) begin
      cw[syn] = ~cw[syn];
    end
    fixed = phrase;
    for (int i = 0; i < 64; i++) begin
      fixed[i] = cw[pos[i]];
    end
    single_err = parity;
    double_err = (syn != 7'h00) && !parity;
  end
endmodule
`default_nettype wire

//--- src/fcp_ctrl.sv
// Flash command sequencer with data-store protection and ECC fault flags.
// Assumes an AXI4-Lite master and a flash array model behind the read port.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// R1: Open bit 7 set disables data-store protection; clear enables sized range.
// R2: Protected range starts 0x10_0000, length 256 bytes times size code plus one.
// R3: Erase inside protected data area is refused, violation flag set.
// R4: Whole data-store block erase refused if any sector is protected.
// R5: Protection load fault at reset clears open bit, sets all size bits.
// R6: Software programs only erased locations, never adds bits without erase.
// R7: Byte and aligned word reads take one cycle, misaligned word two.
// R8: Erased bits read one, programmed bits read zero.
// R9: Reads of the busy block are blocked; other block reads are served.
// R10: Program store is programmed in aligned 8-byte phrases; ECC is SEC-DED.
// R11: Phrase is four 16-bit words plus eight check bits, SEC-DED.
// R12: Whole phrase fetched per read; one single-bit fault corrected.
// R13: Data-store sector is 256 bytes, four 64-byte rows.
// R14: Program store is 64 KB in 64 sectors of 1024 bytes.
// R15: Block erase: code 0x09 and address in slots 0,1; complete flag ends it.
// R16: Block erase flags access error on bad index, mode, address, alignment.
// R17: Block erase flags violation on protection, verify status on verify errors.
// R18: Program sector erase: code 0x0A, any address in the 1024-byte sector.
// R19: Data sector erase flags access error on odd address or bad index.
// R20: Command interrupt raised while complete flag and its enable are set.
// R21: Double and single ECC faults set own flags, each with own enable.
// R22: Index register selects which parameter slot the high/low bytes reach.
// R23: Complete flag reads zero while busy, set after erase and verify.
module fcp_ctrl #(
  parameter int ERASE_CYC  = fcp_pkg::ERASE_CYCLES,
  parameter int VERIFY_CYC = fcp_pkg::VERIFY_CYCLES
) (
  input  wire logic                 clock,
  input  wire logic                 sys_rst,
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire logic                 prot_load_fault,
  input  wire logic                 cmd_mode_ok,
  input  wire fcp_pkg::fcp_rd_req_s rd_req,
  output fcp_pkg::fcp_rd_rsp_s      rd_rsp,
  input  wire logic [63:0]          arr_phrase,
  input  wire logic [7:0]           arr_check,
  input  wire logic                 verify_fail,
  input  wire logic                 verify_uncorr,
  output logic                      erase_strobe,
  output logic                      irq_cmd,
  output logic                      irq_fault
);
  import fcp_pkg::*;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [2:0]  slot_idx_r;
  logic [2:0]  ecc_idx_r;
  logic        cc_en_r;
  logic [1:0]  fault_en_r;
  logic [1:0]  fault_flag_r;
  logic        cc_flag_r;
  logic        acc_err_r;
  logic        viol_r;
  logic [1:0]  verify_r;
  logic [7:0]  pprot_r;
  logic [7:0]  dprot_r;
  logic [15:0] param_r [NUM_SLOTS];
  logic [15:0] ecc_res_r;
  fcp_state_e  state_r;
  logic [31:0] cnt_r;
  logic        cmd_data_r;
  logic        boot_r;

  // AXI write side
  logic        aw_hold_r;
  logic        w_hold_r;
  logic [7:0]  aw_addr_r;
  logic [31:0] w_data_r;
  logic        w_lane_r;
  logic        do_write;
  logic [7:0]  widx;
  logic [7:0]  wb;
  logic        launch;

  assign do_write = aw_hold_r && w_hold_r && !s_axi_bvalid;
  assign widx     = {2'b00, aw_addr_r[7:2]};
  assign wb       = w_data_r[7:0];
  assign launch   = do_write && w_lane_r && widx == IDX_STATUS && wb[BIT_CC_FLAG]
                    && cc_flag_r;

  // ----------------------------------------
  // Bus write channel
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      aw_hold_r     <= 1'b0;
      w_hold_r      <= 1'b0;
      aw_addr_r     <= 8'h00;
      w_data_r      <= 32'h0;
      w_lane_r      <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
    end else begin
      s_axi_awready <= !aw_hold_r && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready  <= !w_hold_r && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r     <= 1'b1;
        aw_addr_r     <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r     <= 1'b1;
        w_data_r     <= s_axi_wdata;
        w_lane_r     <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (widx < IDX_PARAM_INDEX || widx > IDX_ECC_LO) ? 2'b10 : 2'b00;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_hold_r    <= 1'b0;
        w_hold_r     <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Software-written control registers
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      slot_idx_r <= 3'h0;
      ecc_idx_r  <= 3'h0;
      cc_en_r    <= 1'b0;
      fault_en_r <= 2'b00;
      pprot_r    <= 8'hff;
    end else if (do_write && w_lane_r) begin
      case (widx)
        IDX_PARAM_INDEX: slot_idx_r <= wb[2:0];
        IDX_ECC_INDEX:   ecc_idx_r  <= wb[2:0];
        IDX_CONFIG:      cc_en_r    <= wb[BIT_CC_IRQ_EN];
        IDX_FAULT_CFG:   fault_en_r <= wb[1:0];
        IDX_PPROT:       pprot_r    <= wb;
        default: ;
      endcase
    end
  end

  // Protection byte: loaded after reset release so a fault can be seen
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      dprot_r <= RST_DPROT;
      boot_r  <= 1'b1;
    end else if (boot_r) begin
      boot_r <= 1'b0;
      if (prot_load_fault) begin
        dprot_r <= {1'b0, 2'b00, DPS_FULL}; // R5
      end
    end else if (do_write && w_lane_r && widx == IDX_DPROT) begin
      dprot_r <= {wb[BIT_DP_OPEN], 2'b00, wb[4:0]};
    end
  end

  // Parameter slots selected by the index register
  always_ff @(posedge clock) begin
    if (do_write && w_lane_r && cc_flag_r) begin
      if (widx == IDX_PARAM_HI) begin
        param_r[slot_idx_r][15:8] <= wb; // R22
      end
      if (widx == IDX_PARAM_LO) begin
        param_r[slot_idx_r][7:0] <= wb; // R22
      end
    end
  end

  // ----------------------------------------
  // Command decode and protection check
  // ----------------------------------------
  logic [7:0]  cmd_code;
  logic [6:0]  blk;
  logic [15:0] addr;
  logic [22:0] gaddr;
  logic [22:0] prot_end;
  logic        is_data;
  logic        bad_cmd;
  logic        bad_addr;
  logic        protected_hit;

  always_comb begin
    cmd_code = param_r[0][15:8];
    blk      = param_r[0][6:0];
    addr     = param_r[1];
    gaddr    = {blk, addr};
    is_data  = (cmd_code == CMD_ERASE_DSECT) || (blk == BLK_DATA);
    prot_end = DATA_BASE + 23'({dprot_r[4:0], 8'hff}); // R2
    bad_cmd  = !(cmd_code == CMD_ERASE_BLOCK || cmd_code == CMD_ERASE_PSECT
                 || cmd_code == CMD_ERASE_DSECT);
    bad_addr = 1'b0;
    if (cmd_code == CMD_ERASE_DSECT) begin
      gaddr    = DATA_BASE | 23'(addr);
      bad_addr = addr[0]; // R19
    end else if (blk == BLK_PROGRAM) begin
      bad_addr = (cmd_code == CMD_ERASE_BLOCK) && (addr[PHRASE_LOG2-1:0] != 3'h0); // R16
    end else if (blk == BLK_DATA) begin
      bad_addr = (cmd_code == CMD_ERASE_PSECT) || addr[0]; // R16
    end else begin
      bad_addr = 1'b1;
    end
    protected_hit = 1'b0;
    if (!dprot_r[BIT_DP_OPEN] && is_data) begin // R1
      if (cmd_code == CMD_ERASE_BLOCK) begin
        protected_hit = 1'b1; // R4
      end else begin
        protected_hit = {gaddr[22:DSECT_BYTES_LOG2], 8'h00} <= prot_end; // R3 R13
      end
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_r      <= FCP_IDLE;
      cnt_r        <= 32'h0;
      cc_flag_r    <= 1'b1;
      acc_err_r    <= 1'b0;
      viol_r       <= 1'b0;
      verify_r     <= 2'b00;
      cmd_data_r   <= 1'b0;
      erase_strobe <= 1'b0;
    end else begin
      erase_strobe <= 1'b0;
      case (state_r)
        FCP_IDLE: begin
          if (do_write && w_lane_r && widx == IDX_STATUS) begin
            if (wb[BIT_ACC_ERR]) acc_err_r <= 1'b0;
            if (wb[BIT_PROT_VIOL]) viol_r <= 1'b0;
          end
          if (launch && !acc_err_r && !viol_r) begin
            cc_flag_r  <= 1'b0; // R23
            // Latched at launch so the busy block is right from the first busy cycle
            cmd_data_r <= is_data; // R9
            state_r    <= FCP_CHECK;
          end
        end
        FCP_CHECK: begin
          verify_r   <= 2'b00;
          if (slot_idx_r != SLOT_LAUNCH || !cmd_mode_ok || bad_cmd || bad_addr) begin
            acc_err_r <= 1'b1; // R16 R19
            cc_flag_r <= 1'b1;
            state_r   <= FCP_IDLE;
          end else if (protected_hit) begin
            viol_r    <= 1'b1; // R3 R17
            cc_flag_r <= 1'b1;
            state_r   <= FCP_IDLE;
          end else begin
            erase_strobe <= 1'b1; // R14 R15 R18
            cnt_r        <= 32'(ERASE_CYC - 1);
            state_r      <= FCP_ERASE;
          end
        end
        FCP_ERASE: begin
          if (cnt_r == 32'h0) begin
            cnt_r   <= 32'(VERIFY_CYC - 1);
            state_r <= FCP_VERIFY;
          end else begin
            cnt_r <= cnt_r - 32'h1;
          end
        end
        FCP_VERIFY: begin
          if (cnt_r == 32'h0) begin
            verify_r  <= {verify_fail | verify_uncorr, verify_uncorr}; // R17
            cc_flag_r <= 1'b1; // R23
            state_r   <= FCP_IDLE;
          end else begin
            cnt_r <= cnt_r - 32'h1;
          end
        end
        default: state_r <= FCP_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Flash read port with ECC
  // ----------------------------------------
  logic [63:0] fixed;
  logic        sgl;
  logic        dbl;
  logic        rd_busy_blk;
  logic        rd_second_r;
  logic [15:0] rd_word;

  fcp_ecc i_fcp_ecc (
    .phrase     (arr_phrase),
    .check      (arr_check),
    .fixed      (fixed),
    .single_err (sgl),
    .double_err (dbl)
  );

  assign rd_busy_blk = !cc_flag_r && (rd_req.block_data == cmd_data_r); // R9

  always_comb begin
    case (rd_req.addr[2:1])
      2'd0:    rd_word = fixed[15:0];
      2'd1:    rd_word = fixed[31:16];
      2'd2:    rd_word = fixed[47:32];
      default: rd_word = fixed[63:48];
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rd_rsp       <= '0;
      rd_second_r  <= 1'b0;
      fault_flag_r <= 2'b00;
      ecc_res_r    <= 16'h0;
    end else begin
      rd_rsp.valid   <= 1'b0;
      rd_rsp.blocked <= 1'b0;
      if (rd_req.req && rd_busy_blk) begin
        rd_rsp.blocked <= 1'b1; // R9
      end else if (rd_req.req && rd_req.word && rd_req.addr[0] && !rd_second_r) begin
        rd_second_r <= 1'b1; // R7
      end else if (rd_req.req) begin
        rd_second_r  <= 1'b0;
        rd_rsp.valid <= 1'b1; // R7 R8
        rd_rsp.data  <= rd_word; // R11 R12
        if (sgl || dbl) begin
          ecc_res_r <= rd_word;
        end
      end
      // One update so a fault in the clearing cycle is not lost: set wins
      fault_flag_r <= (fault_flag_r & ~((do_write && w_lane_r && widx == IDX_FAULT_STAT)
                                        ? wb[1:0] : 2'b00))
                      | ((rd_req.req && !rd_busy_blk) ? {dbl, sgl & ~dbl} : 2'b00); // R21
    end
  end

  // ----------------------------------------
  // Interrupts and register read
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      irq_cmd   <= 1'b0;
      irq_fault <= 1'b0;
    end else begin
      irq_cmd   <= cc_flag_r && cc_en_r; // R20
      irq_fault <= |(fault_flag_r & fault_en_r); // R21
    end
  end

  logic [7:0] rsel;
  logic [7:0] ridx;
  assign ridx = {2'b00, s_axi_araddr[7:2]};

  always_comb begin
    case (ridx)
      IDX_PARAM_INDEX: rsel = {5'h0, slot_idx_r};
      IDX_ECC_INDEX:   rsel = {5'h0, ecc_idx_r};
      IDX_CONFIG:      rsel = {cc_en_r, 7'h0};
      IDX_FAULT_CFG:   rsel = {6'h0, fault_en_r};
      IDX_STATUS:      rsel = {cc_flag_r, 1'b0, acc_err_r, viol_r, !cc_flag_r, 1'b0, verify_r};
      IDX_FAULT_STAT:  rsel = {6'h0, fault_flag_r};
      IDX_PPROT:       rsel = pprot_r;
      IDX_DPROT:       rsel = dprot_r;
      IDX_PARAM_HI:    rsel = param_r[slot_idx_r][15:8];
      IDX_PARAM_LO:    rsel = param_r[slot_idx_r][7:0];
      IDX_ECC_HI:      rsel = ecc_res_r[15:8];
      IDX_ECC_LO:      rsel = ecc_res_r[7:0];
      default:         rsel = 8'h00;
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= 2'b00;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= {24'h0, rsel};
        s_axi_rresp   <= (ridx < IDX_PARAM_INDEX || ridx > IDX_ECC_LO) ? 2'b10 : 2'b00;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_launch;
    launch && !acc_err_r && !viol_r;
  endsequence

  chk_launch_clears: assert property (@(posedge clock) disable iff (sys_rst) // R23
    s_launch |=> !cc_flag_r) else $error("complete flag not cleared on launch");
  chk_irq_cmd: assert property (@(posedge clock) disable iff (sys_rst) // R20
    (cc_flag_r && cc_en_r) |=> irq_cmd) else $error("command irq missing");
  chk_irq_fault: assert property (@(posedge clock) disable iff (sys_rst) // R21
    irq_fault |-> $past(|(fault_flag_r & fault_en_r))) else $error("fault irq wrong");
  chk_prot_viol: assert property (@(posedge clock) disable iff (sys_rst) // R3
    (state_r == FCP_CHECK && protected_hit && !acc_err_r && slot_idx_r == SLOT_LAUNCH
     && cmd_mode_ok && !bad_cmd && !bad_addr) |=> viol_r && cc_flag_r)
    else $error("protected erase not refused");
  chk_bad_index: assert property (@(posedge clock) disable iff (sys_rst) // R16
    (state_r == FCP_CHECK && slot_idx_r != SLOT_LAUNCH) |=> acc_err_r)
    else $error("bad index accepted");
  chk_open_bit: assert property (@(posedge clock) disable iff (sys_rst) // R1
    dprot_r[BIT_DP_OPEN] |-> !protected_hit) else $error("open bit ignored");
  chk_read_block: assert property (@(posedge clock) disable iff (sys_rst) // R9
    (rd_req.req && rd_busy_blk) |=> rd_rsp.blocked && !rd_rsp.valid)
    else $error("busy block read served");
  chk_misalign_two: assert property (@(posedge clock) disable iff (sys_rst) // R7
    (rd_req.req && rd_req.word && rd_req.addr[0] && !rd_second_r && !rd_busy_blk)
    |=> !rd_rsp.valid) else $error("misaligned read too fast");
  chk_busy_flag: assert property (@(posedge clock) disable iff (sys_rst) // R23
    (state_r == FCP_ERASE) |-> !cc_flag_r) else $error("flag set during erase");
endmodule
`default_nettype wire

//--- verif/tb_flash_command_protect_ctrl.sv
// Self-checking bench for the flash command and protection controller.
// Assumes fcp_pkg and fcp_ctrl are compiled first; the bench is the AXI4-Lite master.
`timescale 1ns/1ps
`default_nettype none
module tb_flash_command_protect_ctrl;
  import fcp_pkg::*;
  logic        clock = 0, sys_rst = 1, awvalid = 0, wvalid = 0, bready = 0;
  logic        arvalid = 0, rready = 0, fault = 0, mode_ok = 1, vfail = 0;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, rd_word;
  logic        awready, wready, bvalid, arready, rvalid, strobe, irq_cmd;
  logic [1:0]  rresp, rd_resp, bresp, wresp;
  logic        irq_flt;
  logic [63:0] phrase = '1; // erased phrase, whole 8-byte unit with its check bits
  logic [7:0]  check = 8'hff;
  fcp_rd_rsp_s rsp;
  int          bad_count = 0, samples_checked = 0, cycles = 0, strobes = 0, want = 0;
  fcp_rd_req_s rd_req = '0;
  // Row: {code, block, protect, index at launch, address, final status}
  logic [55:0] tbl [12] = '{
    56'h12_10_00_01_00fe_90, 56'h12_10_00_01_0100_80, 56'h12_10_15_01_15fe_90,
    56'h12_10_15_01_1600_80, 56'h12_10_80_01_0000_80, 56'h12_10_00_01_0101_a0,
    56'h12_10_00_00_0200_a0, 56'h09_10_00_01_0000_90, 56'h09_10_80_01_0000_80,
    56'h0a_7f_00_01_0123_80, 56'h09_7f_00_01_0004_a0, 56'h09_7f_00_02_0000_a0};

  always #5 clock = ~clock;

  fcp_ctrl #(.ERASE_CYC(20), .VERIFY_CYC(4)) i_fcp_ctrl (
    .clock(clock), .sys_rst(sys_rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .prot_load_fault(fault),
    .cmd_mode_ok(mode_ok), .rd_req(rd_req), .rd_rsp(rsp), .arr_phrase(phrase),
    .arr_check(check), .verify_fail(vfail), .verify_uncorr(vfail),
    .erase_strobe(strobe), .irq_cmd(irq_cmd), .irq_fault(irq_flt));

  // ----------------------------------------
  // Watchdog and erase pulse count
  // ----------------------------------------
  always @(posedge clock) begin
    cycles++;
    if (strobe === 1'b1) strobes++;
    if (cycles == 20000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] dat);
    @(posedge clock);
    awaddr <= idx << 2;
    wdata <= {24'h0, dat};
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge clock);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (bvalid !== 1'b1);
    wresp = bresp;
    bready <= 0;
  endtask

  task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
    @(posedge clock);
    araddr <= idx << 2;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(posedge clock);
      if (arready) arvalid <= 0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 0;
  endtask

  task automatic ex(input logic [7:0] idx, input logic [7:0] exp, input logic [1:0] resp);
    rd(idx, rd_word, rd_resp);
    chk({6'h0, rd_resp, rd_word[7:0]}, {6'h0, resp, exp});
  endtask

  // Read port: q = {data block, word, address}, e = {valid, blocked, data}, n request cycles
  task automatic fread(input logic [17:0] q, input int n, input logic [17:0] e);
    @(posedge clock);
    rd_req <= {1'b1, q[17], q[15:0], q[16]};
    repeat (n) @(posedge clock);
    rd_req <= '0;
    chk({15'h0, rsp.valid}, 16'h0000);
    @(posedge clock);
    chk({14'h0, rsp.valid, rsp.blocked}, {14'h0, e[17:16]});
    if (e[17]) chk(rsp.data, e[15:0]);
  endtask

  task automatic test_ecc();
    fread(18'h1_0003, 2, 18'h2_ffff);
    fread(18'h0_0001, 1, 18'h2_ffff);
    phrase <= 64'h1;
    check <= 8'h00;
    fread(18'h1_0000, 1, 18'h2_0000);
    ex(IDX_FAULT_STAT, 8'h01, 2'b00);
    chk({15'h0, irq_flt}, 16'h0000);
    wr(IDX_FAULT_CFG, 8'h01);
    repeat (2) @(posedge clock);
    chk({15'h0, irq_flt}, 16'h0001);
    phrase <= 64'h3;
    fread(18'h1_0000, 1, 18'h2_0003);
    ex(IDX_FAULT_STAT, 8'h03, 2'b00);
    ex(IDX_ECC_LO, 8'h03, 2'b00);
    wr(IDX_FAULT_STAT, 8'h03);
    ex(IDX_FAULT_STAT, 8'h00, 2'b00);
    $display("test ecc done");
  endtask

  // Busy look is skipped for refused launches: the flag returns after one check cycle
  task automatic cmd(input logic [55:0] t);
    logic d;
    d = (t[55:48] == CMD_ERASE_DSECT) || (t[47:40] == BLK_DATA);
    wr(IDX_PARAM_INDEX, 8'h00);
    wr(IDX_PARAM_HI, t[55:48]);
    wr(IDX_PARAM_LO, t[47:40]);
    wr(IDX_PARAM_INDEX, 8'h01);
    wr(IDX_PARAM_HI, t[23:16]);
    wr(IDX_PARAM_LO, t[15:8]);
    wr(IDX_PARAM_INDEX, t[31:24]);
    wr(IDX_STATUS, 8'h80);
    rd(IDX_STATUS, rd_word, rd_resp);
    if (!t[5] && !t[4]) begin
      want++;
      chk({14'h0, rd_word[7], rd_word[3]}, 16'h0001);
      fread({d, 1'b1, 16'h0002}, 1, 18'h1_0000);
      fread({!d, 1'b1, 16'h0002}, 1, 18'h2_ffff);
    end
    repeat (60) if (rd_word[7] !== 1'b1) rd(IDX_STATUS, rd_word, rd_resp);
    chk({8'h00, rd_word[7:0]}, {8'h00, t[7:0]});
    wr(IDX_STATUS, 8'h30);
  endtask

  task automatic do_reset(input logic f);
    sys_rst <= 1;
    fault <= f;
    repeat (8) @(posedge clock);
    sys_rst <= 0;
    @(posedge clock);
    fault <= 0;
  endtask

  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    do_reset(1'b0);
    ex(IDX_STATUS, RST_STATUS, 2'b00);
    ex(IDX_DPROT, RST_DPROT, 2'b00);
    ex(IDX_RSV_B, 8'h00, 2'b00);
    rd(8'h10, rd_word, rd_resp);
    chk({14'h0, rd_resp}, 16'h0002);
    wr(8'h10, 8'h00);
    chk({14'h0, wresp}, 16'h0002);
    $display("test reset done");
    wr(IDX_PARAM_INDEX, 8'h02);
    wr(IDX_PARAM_HI, 8'h5a);
    wr(IDX_PARAM_INDEX, 8'h03);
    wr(IDX_PARAM_HI, 8'ha5);
    wr(IDX_PARAM_INDEX, 8'h02);
    ex(IDX_PARAM_HI, 8'h5a, 2'b00);
    $display("test slots done");
    wr(IDX_CONFIG, 8'h80);
    foreach (tbl[i]) begin
      wr(IDX_DPROT, tbl[i][39:32]);
      cmd(tbl[i]);
    end
    mode_ok <= 0;
    cmd(56'h0a_7f_00_01_0000_a0);
    mode_ok <= 1;
    vfail <= 1;
    cmd(56'h0a_7f_00_01_0400_83);
    vfail <= 0;
    chk(16'(strobes), 16'(want));
    chk({15'h0, irq_cmd}, 16'h0001);
    wr(IDX_CONFIG, 8'h00);
    repeat (3) @(posedge clock);
    chk({15'h0, irq_cmd}, 16'h0000);
    $display("test commands done");
    test_ecc();
    do_reset(1'b1);
    ex(IDX_DPROT, {3'b000, DPS_FULL}, 2'b00);
    cmd(56'h12_10_00_01_1ffe_90);
    $display("test load fault done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
